// file: verilog/gpin_top.v
`timescale 1ns/1ps
`include "gpin_consts.vh"
module gpin_top #(
   parameter PULSE_CYC = (`GPIN_CLK_HZ / 1000000) * `GPIN_PULSE_US,
   parameter POLL_CYC = (`GPIN_CLK_HZ / 1000) * `GPIN_POLL_MS
) (
   // clock and reset
   input wire sys_clk,
   input wire sys_rst,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // measurements and gauge events
   input wire [11:0] thermistor_input,
   input wire [11:0] internal_temp,
   input wire [7:0] relative_charge_pct,
   input wire [1:0] charge_state,
   input wire low_charge_flag,
   input wire system_shutdown_level,
   input wire ocv_cmd_req,
   input wire ocv_busy,
   input wire ocv_is_init,
   // pins
   input wire presence_detect_in,
   output wire presence_detect_out,
   output wire presence_detect_oe,
   output reg battery_good_out,
   output reg soc_irq_out,
   output reg adc_ground_sel,
   output reg external_temp_sel
);
   ////////////////////////////////////////////////////////////////
   reg [31:0] cfg_q;
   reg [31:0] lim_q;
   wire good_polarity_sel = cfg_q[0];
   wire irq_polarity_sel = cfg_q[1];
   wire [1:0] pin_function_code = cfg_q[3:2];
   wire low_charge_irq_en = cfg_q[4];
   wire removal_irq_en = cfg_q[5];
   wire init_measure_irq_en = cfg_q[6];
   wire [7:0] soc_step = cfg_q[15:8];
   wire [7:0] t_low = lim_q[7:0];
   wire [7:0] t_high = lim_q[15:8];
   wire [7:0] t_hys = lim_q[23:16];
   reg present_q, ocv_done_q, inhibit_q, prev_init_q;
   reg charge_inhibit_flag, voltage_cmd_fail_flag;
   reg [11:0] temp_q;
   reg [31:0] poll_cnt_q;
   reg [7:0] ev_pend_q;
   reg [31:0] pulse_cnt_q;
   reg pulsing_q;
   reg [7:0] soc_prev_q;
   reg [1:0] st_prev_q;
   reg low_prev_q, sd_prev_q;
   reg prev_present_fall;
   wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // mode 1 is 2'b01, other codes never inhibit
   wire mode1 = pin_function_code == `GPIN_PFC_MODE1;
   ////////////////////////////////////////////////////////////////
   // presence: never driven, so the pull-up sets the level
   assign presence_detect_out = 1'b0;
   assign presence_detect_oe = 1'b0;
   // temperature source and ground follow config
   wire [11:0] temp_src = external_temp_sel ? thermistor_input :
      internal_temp;
   wire [7:0] temp_c = temp_src[11:4];
   wire open_therm = thermistor_input >= `GPIN_NEAR_OPEN;
   // step point crossing: (pct-1) div step boundary
   function [7:0] step_idx;
      input [7:0] pct;
      input [7:0] stp;
      begin
         if (pct == 8'h00 || stp == 8'h00)
            step_idx = 8'h00;
         else
            step_idx = (pct - 8'h01) / stp + 8'h01;
      end
   endfunction
   wire stepping = soc_step != 8'h00;
   wire [7:0] idx_now = step_idx(relative_charge_pct, soc_step);
   wire [7:0] idx_old = step_idx(soc_prev_q, soc_step);
   wire ev_chg = stepping && charge_state == `GPIN_ST_CHG &&
      (idx_now > idx_old || (relative_charge_pct >= 8'h64 &&
      soc_prev_q < 8'h64));
   wire ev_dsg = stepping && charge_state == `GPIN_ST_DSG &&
      (idx_now < idx_old);
   wire ev_low = low_charge_irq_en &&
      (low_charge_flag != low_prev_q);
   wire ev_sd = system_shutdown_level != sd_prev_q;
   wire ev_st = stepping && charge_state != st_prev_q;
   wire ev_rem = removal_irq_en && prev_present_fall;
   wire ev_fail = ocv_cmd_req && charge_inhibit_flag;
   // command-length pulse while a measurement runs, the init one only when enabled
   wire hold_pulse = ocv_busy && (!ocv_is_init || init_measure_irq_en);
   wire [7:0] new_ev = {1'b0, ev_fail, ev_rem, ev_st, ev_sd, ev_low,
      ev_dsg, ev_chg};
   // serve the lowest pending event, keep the others queued
   wire [7:0] ev_all = ev_pend_q | new_ev;
   wire [7:0] ev_served = ev_all & (~ev_all + 8'h01);
   always @* begin
      prev_present_fall = present_q && poll_cnt_q == 32'h0 &&
         (presence_detect_in || open_therm);
   end
   ////////////////////////////////////////////////////////////////
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_q <= `GPIN_CFG_RST;
         lim_q <= `GPIN_LIM_RST;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req && wb_we_i) begin
            if (wb_adr_i == `GPIN_A_CFG) begin
               if (wb_sel_i[0]) cfg_q[7:0] <= wb_dat_i[7:0];
               if (wb_sel_i[1]) cfg_q[15:8] <= wb_dat_i[15:8];
               if (wb_sel_i[2]) cfg_q[23:16] <= wb_dat_i[23:16];
            end
            if (wb_adr_i == `GPIN_A_LIM) begin
               if (wb_sel_i[0]) lim_q[7:0] <= wb_dat_i[7:0];
               if (wb_sel_i[1]) lim_q[15:8] <= wb_dat_i[15:8];
               if (wb_sel_i[2]) lim_q[23:16] <= wb_dat_i[23:16];
            end
         end
         if (bus_req) begin
            case (wb_adr_i)
               `GPIN_A_CFG: wb_dat_o <= {8'h0, cfg_q[23:0]};
               `GPIN_A_LIM: wb_dat_o <= {8'h0, lim_q[23:0]};
               // temperature readable in any mode
               `GPIN_A_MEAS: wb_dat_o <= {20'h0, temp_q};
               `GPIN_A_STAT: wb_dat_o <= {26'h0, voltage_cmd_fail_flag,
                  charge_inhibit_flag, ocv_done_q, present_q,
                  pulsing_q, inhibit_q};
               default: wb_dat_o <= 32'h0;
            endcase
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         present_q <= 1'b0;
         ocv_done_q <= 1'b0;
         inhibit_q <= 1'b0;
         charge_inhibit_flag <= 1'b0;
         voltage_cmd_fail_flag <= 1'b0;
         temp_q <= 12'h0;
         poll_cnt_q <= 32'h0;
         prev_init_q <= 1'b0;
         external_temp_sel <= 1'b1;
         adc_ground_sel <= 1'b1;
      end else begin
         temp_q <= temp_src;
         external_temp_sel <= cfg_q[7];
         adc_ground_sel <= cfg_q[16];
         prev_init_q <= ocv_busy && ocv_is_init;
         // poll once per second
         if (poll_cnt_q == 32'h0) begin
            poll_cnt_q <= POLL_CYC - 1;
            if (!presence_detect_in && !open_therm)
               present_q <= 1'b1;
            else begin
               present_q <= 1'b0;
               ocv_done_q <= 1'b0;
            end
         end else
            poll_cnt_q <= poll_cnt_q - 32'h1;
         if (present_q && prev_init_q && !(ocv_busy && ocv_is_init))
            ocv_done_q <= 1'b1;
         // hysteresis window
         if (!mode1)
            inhibit_q <= 1'b0;
         else if (temp_c < t_low || temp_c > t_high)
            inhibit_q <= 1'b1;
         else if (temp_c >= t_low + t_hys && temp_c <= t_high - t_hys)
            inhibit_q <= 1'b0;
         charge_inhibit_flag <= inhibit_q;
         if (ev_fail)
            voltage_cmd_fail_flag <= 1'b1;
         else if (ocv_cmd_req)
            voltage_cmd_fail_flag <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////
   // events queue and go out one at a time
   integer i;
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ev_pend_q <= 8'h0;
         pulse_cnt_q <= 32'h0;
         pulsing_q <= 1'b0;
         soc_prev_q <= 8'h0;
         st_prev_q <= 2'h0;
         low_prev_q <= 1'b0;
         sd_prev_q <= 1'b0;
         battery_good_out <= 1'b1;
         soc_irq_out <= 1'b1;
      end else begin
         soc_prev_q <= relative_charge_pct;
         st_prev_q <= charge_state;
         low_prev_q <= low_charge_flag;
         sd_prev_q <= system_shutdown_level;
         if (pulsing_q) begin
            ev_pend_q <= ev_pend_q | new_ev;
            if (pulse_cnt_q == 32'h1)
               pulsing_q <= 1'b0;
            pulse_cnt_q <= pulse_cnt_q - 32'h1;
         end else if (ev_all != 8'h0) begin
            pulsing_q <= 1'b1;
            pulse_cnt_q <= PULSE_CYC;
            ev_pend_q <= ev_all & ~ev_served;
         end
         // level follows polarity, clear means low-active
         battery_good_out <= (present_q && ocv_done_q && !inhibit_q) ~^
            good_polarity_sel;
         soc_irq_out <= (pulsing_q || hold_pulse) ~^ irq_polarity_sel;
      end
   end
endmodule

// file: shared/gpin_consts.vh
// Contract
// - hold good output negated until voltage reading
// - assert good output after voltage reading
// - good output level follows polarity bit
// - mode 1 negates good outside temperature window
// - re-assert only inside hysteresis-narrowed window
// - release presence pin; high absent, low present
// - sample presence pin once every second
// - thermistor near 2.5V means disconnected
// - charging pulse at each step point, 100%
// - discharging pulse below step points and 0%
// - low-charge threshold pulse when enabled
// - shutdown threshold crossings always pulse
// - state change pulses when step nonzero
// - removal pulse when removal enable set
// - voltage command refused under inhibit, flag, pulse
// - pulse spans post-init voltage command
// - pulse spans first init measurement if enabled
// - external sensor when select set, else internal
// - config bit selects converter ground
// - temperature readable at any time
// - good polarity clear low-active, default clear
// - interrupt polarity clear low-active
// - pin function code 0/0,0/1,1/0 modes
// - low-charge enable gates threshold pulses
`ifndef GPIN_CONSTS_VH
`define GPIN_CONSTS_VH
`define GPIN_CLK_HZ 40000000
`define GPIN_PULSE_US 1000
`define GPIN_POLL_MS 1000
`define GPIN_PFC_MODE1 2'h1
`define GPIN_ST_CHG 2'h1
`define GPIN_ST_DSG 2'h2
`define GPIN_NEAR_OPEN 12'hf00
// register byte addresses
`define GPIN_A_CFG 4'h0
`define GPIN_A_LIM 4'h4
`define GPIN_A_MEAS 4'h8
`define GPIN_A_STAT 4'hc
`define GPIN_CFG_RST 32'h0001_0084
`define GPIN_LIM_RST 32'h0a05_2d00
`endif

// file: test/gpin_props.sv
`timescale 1ns/1ps
module gpin_props #(
   parameter PULSE_CYC = 8,
   parameter POLL_CYC = 16
) (
   // clock, reset, bus
   input wire sys_clk,
   input wire sys_rst,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o,
   // gauge side
   input wire ocv_busy,
   input wire ocv_is_init,
   input wire presence_detect_oe,
   input wire battery_good_out,
   input wire soc_irq_out,
   input wire adc_ground_sel,
   input wire external_temp_sel
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   // skip the first busy cycles, the pulse edge lands there
   sequence s_busy(bit ini);
      ocv_busy && $past(ocv_busy) && $past(ocv_busy, 2) && ocv_is_init == ini;
   endsequence
   a_ack_follows: assert property (s_req |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_caused: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_pin_released: assert property (!presence_detect_oe)
      else $error("presence pin driven");
   a_good_in_ocv: assert property (s_busy(1'b1) |-> $stable(battery_good_out))
      else $error("good moved during reading");
   a_irq_init_span: assert property (s_busy(1'b1) |-> $stable(soc_irq_out))
      else $error("irq moved during first reading");
   a_irq_cmd_span: assert property (s_busy(1'b0) |-> $stable(soc_irq_out))
      else $error("irq moved during command");
   a_sel_on_write: assert property ($changed({external_temp_sel, adc_ground_sel}) |-> wb_ack_o || $past(wb_ack_o) || $past(wb_ack_o, 2))
      else $error("select changed without write");
endmodule

// file: test/gpin_batt.sv
`timescale 1ns/1ps
module gpin_batt (
   // battery state
   input wire insert,
   input wire [11:0] temp_code,
   // pins
   input wire presence_detect_out,
   input wire presence_detect_oe,
   output wire presence_detect_in,
   output wire [11:0] thermistor_input
);
   // released pin: pull-up wins unless a pack pulls it down
   assign presence_detect_in = presence_detect_oe ? presence_detect_out : !insert;
   // open thermistor floats to the top of the range
   assign thermistor_input = insert ? temp_code : 12'hfff;
endmodule

// file: test/gpin_top_tb.sv
`timescale 1ns/1ps
module gpin_top_tb;
   localparam PC = 8;
   localparam QC = 16;
   logic sys_clk, sys_rst, cyc, stb, we, ins, lcf, ssl, busy, init, req;
   logic [3:0] adr;
   logic [31:0] dat, rd;
   logic [11:0] tcode, itemp;
   logic [7:0] pct;
   logic [1:0] cst;
   logic [11:0] ev [6] = '{12'h132, 12'h133, 12'h233, 12'h232, 12'h632, 12'he32};
   wire [31:0] dat_o;
   wire [11:0] therm;
   wire ack, pin_o, pin_oe, pin_i, good, irq, gnd, tsel;
   integer seed = 61, err_total = 0, n_tests = 0, w, i;
   gpin_top #(.PULSE_CYC(PC), .POLL_CYC(QC)) i_dut (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .thermistor_input(therm), .internal_temp(itemp),
      .relative_charge_pct(pct), .charge_state(cst), .low_charge_flag(lcf),
      .system_shutdown_level(ssl), .ocv_cmd_req(req), .ocv_busy(busy),
      .ocv_is_init(init), .presence_detect_in(pin_i),
      .presence_detect_out(pin_o), .presence_detect_oe(pin_oe),
      .battery_good_out(good), .soc_irq_out(irq), .adc_ground_sel(gnd),
      .external_temp_sel(tsel));
   gpin_batt i_batt (.insert(ins), .temp_code(tcode),
      .presence_detect_out(pin_o), .presence_detect_oe(pin_oe),
      .presence_detect_in(pin_i), .thermistor_input(therm));
   initial begin
      sys_clk = 0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) itemp <= $random(seed);
   task idle(input integer n);
      repeat (n) @(posedge sys_clk);
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task wb(input logic wr, input logic [3:0] a, input logic [31:0] d);
      integer n;
      n = 0;
      @(posedge sys_clk);
      cyc <= 1; stb <= 1; we <= wr; adr <= a; dat <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      rd = dat_o;
      if (n >= 50) err_total++;
      cyc <= 0; stb <= 0;
   endtask
   // width of the next active-low pulse, bounded both ways
   task pulse(output integer wd);
      integer n;
      wd = 0; n = 0;
      while (irq !== 1'b0 && n < 80) begin
         @(posedge sys_clk); n++;
      end
      while (irq === 1'b0 && wd < 100) begin
         @(posedge sys_clk); wd++;
      end
   endtask
   task end_of_test;
      $display("mismatches %0d of %0d checks", err_total, n_tests);
      if (err_total == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      #(25 * 20000);
      err_total++;
      end_of_test;
   end
   initial begin
      sys_rst = 1; cyc = 0; stb = 0; we = 0; adr = 0; dat = 0; ins = 0;
      tcode = 12'h190; itemp = 0; {lcf, ssl, cst, pct} = 12'h032;
      busy = 0; init = 0; req = 0;
      idle(3);
      chk("good in reset", good, 1);
      chk("irq in reset", irq, 1);
      sys_rst <= 0;
      wb(1, 4'h0, 32'h0001_0af4);
      wb(0, 4'h0, 0); chk("config", rd, 32'h0001_0af4);
      chk("temp select", tsel, 1);
      chk("ground select", gnd, 1);
      wb(1, 4'h4, 32'h00052d00);
      wb(0, 4'h4, 0); chk("limits", rd, 32'h00052d00);
      wb(0, 4'h2, 0); chk("unmapped", rd, 0);
      wb(0, 4'h8, 0); chk("temperature", rd, 32'h0fff);
      ins <= 1; idle(2 * QC + 4);
      chk("good before ocv", good, 1);
      init <= 1; busy <= 1; idle(4);
      chk("irq first ocv", irq, 0);
      idle(8); busy <= 0; idle(PC + 4);
      chk("good after ocv", good, 0);
      init <= 0; busy <= 1; idle(4);
      chk("irq ocv cmd", irq, 0);
      busy <= 0; idle(PC + 4);
      tcode <= 12'h300; idle(2 * QC + 4);
      chk("good hot", good, 1);
      req <= 1; @(posedge sys_clk); req <= 0;
      pulse(w); chk("voltage_cmd_fail_flag pulse", w, PC);
      wb(0, 4'hc, 0); chk("voltage_cmd_fail_flag flag", rd[5], 1);
      tcode <= 12'h2c0; idle(2 * QC + 4);
      chk("good in hysteresis", good, 1);
      tcode <= 12'h280; idle(2 * QC + 4);
      chk("good cooled", good, 0);
      for (i = 0; i < 6; i++) begin
         idle(1 + ($random(seed) & 3));
         {lcf, ssl, cst, pct} <= ev[i];
         pulse(w); chk("event pulse", w, PC);
      end
      ins <= 0;
      pulse(w); chk("removal pulse", w, PC);
      chk("good removed", good, 1);
      wb(1, 4'h0, 32'h0000_0af7); idle(4);
      chk("ground cleared", gnd, 0);
      chk("irq idle inverted", irq, 0);
      chk("good inverted", good, 0);
      end_of_test;
   end
endmodule
bind gpin_top gpin_props #(.PULSE_CYC(PULSE_CYC), .POLL_CYC(POLL_CYC)) i_props (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .ocv_busy(ocv_busy),
   .ocv_is_init(ocv_is_init), .presence_detect_oe(presence_detect_oe),
   .battery_good_out(battery_good_out), .soc_irq_out(soc_irq_out),
   .adc_ground_sel(adc_ground_sel), .external_temp_sel(external_temp_sel));
